// ==== verilog/rop_pkg.sv ====
// constants for the pixel raster-op and clip stage
`default_nettype none
package rop_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned CW = 16;
  localparam int unsigned PAT_N = 16;
  localparam int unsigned PAT_AW = 4;
  localparam int unsigned AW = 8;
  // op-code field layout
  localparam int unsigned CMD_LSB = 8;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned AREA_LSB = 5;
  localparam int unsigned AREA_W = 3;
  localparam int unsigned COLM_LSB = 3;
  localparam int unsigned COLM_W = 2;
  localparam int unsigned ROPF_LSB = 0;
  localparam int unsigned ROPF_W = 3;
  localparam int unsigned PXW_LSB = 16;
  localparam int unsigned PXW_W = 3;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COL0 = 8'h04;
  localparam logic [7:0] OFF_COL1 = 8'h08;
  localparam logic [7:0] OFF_CMPC = 8'h0C;
  localparam logic [7:0] OFF_PCTRL = 8'h10;
  localparam logic [7:0] OFF_PPTR = 8'h14;
  localparam logic [7:0] OFF_AREA_X = 8'h18;
  localparam logic [7:0] OFF_AREA_Y = 8'h1C;
  localparam logic [7:0] OFF_ORIGIN = 8'h20;
  localparam logic [7:0] OFF_CURPTR = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_PATWR = 8'h2C;
  // status bits
  localparam int unsigned ST_ABORT = 0;
  localparam int unsigned ST_AREA = 1;
  localparam int unsigned ST_STOP = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] COL_RST = 16'h0000;
  localparam logic [15:0] PCTRL_RST = 16'hFF00;
  // raster operations
  typedef enum logic [2:0] {
    ROP_REPL = 3'h0, ROP_OR = 3'h1, ROP_AND = 3'h2, ROP_XOR = 3'h3,
    ROP_EQ = 3'h4, ROP_NE = 3'h5, ROP_LT = 3'h6, ROP_GT = 3'h7
  } rop_op_t;
  // colour source modes
  localparam logic [1:0] COLM_BOTH = 2'h0;
  localparam logic [1:0] COLM_ONE = 2'h1;
  localparam logic [1:0] COLM_ZERO = 2'h2;
  localparam logic [1:0] COLM_DIRECT = 2'h3;
  // area modes
  localparam logic [2:0] AREA_EXIT_ABORT = 3'h1;
  localparam logic [2:0] AREA_ENTER_ABORT = 3'h5;
  localparam logic [2:0] AREA_OUT_CLIP = 3'h2;
  localparam logic [2:0] AREA_OUT_FLAG = 3'h3;
  localparam logic [2:0] AREA_IN_CLIP = 3'h6;
  localparam logic [2:0] AREA_IN_FLAG = 3'h7;
  // graphic copy command codes, arbitrary values
  localparam logic [7:0] CMD_ABS_COPY = 8'hA0;
  localparam logic [7:0] CMD_REL_COPY = 8'hA4;
endpackage
`default_nettype wire

// ==== verilog/rop_pattern_mem.sv ====
// pattern memory, one row per word, registered read
`timescale 1ns/10ps
`default_nettype none
module rop_pattern_mem #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 16,
  parameter int unsigned A = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [A-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [A-1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// ==== verilog/rop_top.sv ====
// per-point colour select, raster operation and area check with apb registers
// Notes on behaviour
// - op-code splits into command, area, colour, op
// - op 000 writes colour data unconditionally
// - op 001 writes read data OR colour
// - op 010 writes read data AND colour
// - op 011 writes read data XOR colour
// - op 100 replaces only if pixel equals compare
// - op 101 replaces only if pixel differs
// - op 110 replaces only if pixel below colour
// - op 111 replaces only if pixel above colour
// - colour from register by pattern, copy uses source
// - less/greater compare uses same colour choice
// - colour mode 00 picks register by bit
// - modes 01/10 suppress on bit zero/one
// - colour mode 11 uses pattern row directly
// - 16x16 pattern scanned between start and end
// - area 000/100 draws without any check
// - area 001 aborts when leaving area
// - area 101 aborts when entering area
// - area 010/011 clip outside, 011 flags
// - area 110/111 clip inside, 111 flags
// - absolute points are offset by origin
// - relative points are offset by current pointer
`timescale 1ns/10ps
`default_nettype none
module rop_top (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CMD_START,
  input wire logic PT_VALID,
  input wire logic PT_REL,
  input wire logic [15:0] PT_X,
  input wire logic [15:0] PT_Y,
  input wire logic [15:0] PT_SRC_DATA,
  input wire logic [15:0] FB_RDATA,
  output logic PT_READY,
  output logic WR_VALID,
  output logic WR_SUPPRESS,
  output logic [15:0] WR_DATA,
  output logic [15:0] WR_X,
  output logic [15:0] WR_Y,
  output logic ABORT,
  output logic AREA_DETECT
);
  logic [31:0] ctrl_q;
  logic [15:0] colour_reg_zero_q, colour_reg_one_q, compare_colour_q, pattern_ctrl_reg_q;
  logic [31:0] area_x_q, area_y_q, origin_q, cur_q;
  logic [3:0] pattern_ptr_x_q, pattern_ptr_y_q;
  logic abort_flag_q, area_detect_flag_q, stop_q;
  logic s1_v_q;
  logic [15:0] s1_x_q, s1_y_q, s1_fb_q, s1_src_q;
  logic [3:0] s1_ppx_q;
  logic [15:0] pat_row;

  // register decode
  wire logic setup = PSEL & ~PENABLE;
  wire logic wr_en = PSEL & PENABLE & PWRITE & PREADY;
  wire logic hit_ctrl = PADDR == rop_pkg::OFF_CTRL;
  wire logic hit_col0 = PADDR == rop_pkg::OFF_COL0;
  wire logic hit_col1 = PADDR == rop_pkg::OFF_COL1;
  wire logic hit_cmpc = PADDR == rop_pkg::OFF_CMPC;
  wire logic hit_pctrl = PADDR == rop_pkg::OFF_PCTRL;
  wire logic hit_pptr = PADDR == rop_pkg::OFF_PPTR;
  wire logic hit_ax = PADDR == rop_pkg::OFF_AREA_X;
  wire logic hit_ay = PADDR == rop_pkg::OFF_AREA_Y;
  wire logic hit_org = PADDR == rop_pkg::OFF_ORIGIN;
  wire logic hit_cur = PADDR == rop_pkg::OFF_CURPTR;
  wire logic hit_st = PADDR == rop_pkg::OFF_STATUS;
  wire logic hit_pat = PADDR == rop_pkg::OFF_PATWR;
  wire logic hit_any = hit_ctrl | hit_col0 | hit_col1 | hit_cmpc | hit_pctrl | hit_pptr |
                       hit_ax | hit_ay | hit_org | hit_cur | hit_st | hit_pat;
  wire logic [31:0] status_word = {29'h0, stop_q, area_detect_flag_q, abort_flag_q};
  wire logic [31:0] rd_mux =
      hit_ctrl ? ctrl_q :
      hit_col0 ? {16'h0, colour_reg_zero_q} :
      hit_col1 ? {16'h0, colour_reg_one_q} :
      hit_cmpc ? {16'h0, compare_colour_q} :
      hit_pctrl ? {16'h0, pattern_ctrl_reg_q} :
      hit_pptr ? {24'h0, pattern_ptr_y_q, pattern_ptr_x_q} :
      hit_ax ? area_x_q :
      hit_ay ? area_y_q :
      hit_org ? origin_q :
      hit_cur ? cur_q :
      hit_st ? status_word : 32'h0;

  // op-code fields
  wire logic [7:0] cmd_code = ctrl_q[rop_pkg::CMD_LSB +: rop_pkg::CMD_W];
  wire logic [2:0] area_mode = ctrl_q[rop_pkg::AREA_LSB +: rop_pkg::AREA_W];
  wire logic [1:0] colour_mode = ctrl_q[rop_pkg::COLM_LSB +: rop_pkg::COLM_W];
  wire logic [2:0] raster_op_field = ctrl_q[rop_pkg::ROPF_LSB +: rop_pkg::ROPF_W];
  wire logic [2:0] pix_w = ctrl_q[rop_pkg::PXW_LSB +: rop_pkg::PXW_W];
  wire logic copy_cmd = (cmd_code == rop_pkg::CMD_ABS_COPY) |
                        (cmd_code == rop_pkg::CMD_REL_COPY);
  wire logic [3:0] pattern_start_x = pattern_ctrl_reg_q[3:0];
  wire logic [3:0] pattern_start_y = pattern_ctrl_reg_q[7:4];
  wire logic [3:0] pattern_end_x = pattern_ctrl_reg_q[11:8];
  wire logic [3:0] pattern_end_y = pattern_ctrl_reg_q[15:12];

  // point acceptance and coordinate resolve
  wire logic accept = PT_VALID & PT_READY;
  wire logic [15:0] base_x = PT_REL ? cur_q[15:0] : origin_q[15:0];
  wire logic [15:0] base_y = PT_REL ? cur_q[31:16] : origin_q[31:16];
  wire logic [15:0] abs_x = base_x + PT_X;
  wire logic [15:0] abs_y = base_y + PT_Y;
  wire logic x_end = pattern_ptr_x_q == pattern_end_x;
  wire logic y_end = pattern_ptr_y_q == pattern_end_y;

  // pixel field within the frame-buffer word
  wire logic [4:0] pbits = 5'h01 << pix_w;
  wire logic [3:0] idx_mask = 4'(5'h10 >> pix_w) - 4'h1;
  wire logic [3:0] pshift = 4'((s1_x_q[3:0] & idx_mask) << pix_w);
  wire logic [15:0] low_mask = 16'((17'h1_0000 >> (5'h10 - pbits)) - 17'h0_0001);
  wire logic [15:0] pmask = low_mask << pshift;

  // colour data selection
  wire logic pat_bit = pat_row[s1_ppx_q];
  wire logic [15:0] col_word = copy_cmd ? s1_src_q :
                               (colour_mode == rop_pkg::COLM_DIRECT) ? pat_row :
                               pat_bit ? colour_reg_one_q : colour_reg_zero_q;
  wire logic col_sup = ~copy_cmd & (((colour_mode == rop_pkg::COLM_ONE) & ~pat_bit) |
                                    ((colour_mode == rop_pkg::COLM_ZERO) & pat_bit));
  wire logic [15:0] rd_pix = (s1_fb_q & pmask) >> pshift;
  wire logic [15:0] cl_pix = (col_word & pmask) >> pshift;
  wire logic [15:0] cc_pix = (compare_colour_q & pmask) >> pshift;

  // area check
  wire logic in_area = ($signed(s1_x_q) >= $signed(area_x_q[15:0])) &
                       ($signed(s1_x_q) <= $signed(area_x_q[31:16])) &
                       ($signed(s1_y_q) >= $signed(area_y_q[15:0])) &
                       ($signed(s1_y_q) <= $signed(area_y_q[31:16]));
  wire logic abort_hit = s1_v_q & ~stop_q &
                         (((area_mode == rop_pkg::AREA_EXIT_ABORT) & ~in_area) |
                          ((area_mode == rop_pkg::AREA_ENTER_ABORT) & in_area));
  wire logic clip_out = (area_mode == rop_pkg::AREA_OUT_CLIP) |
                        (area_mode == rop_pkg::AREA_OUT_FLAG);
  wire logic clip_in = (area_mode == rop_pkg::AREA_IN_CLIP) |
                       (area_mode == rop_pkg::AREA_IN_FLAG);
  wire logic area_sup = (clip_out & ~in_area) | (clip_in & in_area);
  wire logic ard_hit = s1_v_q & ~stop_q &
                       (((area_mode == rop_pkg::AREA_OUT_FLAG) & ~in_area) |
                        ((area_mode == rop_pkg::AREA_IN_FLAG) & in_area));

  // raster operation
  logic [15:0] op_word;
  logic cond_ok;
  always_comb begin
    op_word = col_word;
    cond_ok = 1'b1;
    unique case (rop_pkg::rop_op_t'(raster_op_field))
      rop_pkg::ROP_REPL: op_word = col_word;
      rop_pkg::ROP_OR: op_word = s1_fb_q | col_word;
      rop_pkg::ROP_AND: op_word = s1_fb_q & col_word;
      rop_pkg::ROP_XOR: op_word = s1_fb_q ^ col_word;
      rop_pkg::ROP_EQ: cond_ok = rd_pix == cc_pix;
      rop_pkg::ROP_NE: cond_ok = rd_pix != cc_pix;
      rop_pkg::ROP_LT: cond_ok = rd_pix < cl_pix;
      rop_pkg::ROP_GT: cond_ok = rd_pix > cl_pix;
    endcase
  end
  wire logic sup1 = col_sup | area_sup | ~cond_ok | stop_q | abort_hit;
  wire logic [15:0] merged = (s1_fb_q & ~pmask) | (op_word & pmask);
  wire logic stop_d = (stop_q & ~CMD_START) | abort_hit;

  rop_pattern_mem #(
    .W(rop_pkg::PAT_N),
    .D(rop_pkg::PAT_N),
    .A(rop_pkg::PAT_AW)
  ) u_pat (
    .clk(CLK_SYS),
    .we(wr_en & hit_pat),
    .waddr(PWDATA[3:0]),
    .wdata(PWDATA[31:16]),
    .raddr(pattern_ptr_y_q),
    .rdata_q(pat_row)
  );

  // apb slave, one access cycle
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~hit_any;
      PRDATA <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= rop_pkg::CTRL_RST;
      colour_reg_zero_q <= rop_pkg::COL_RST;
      colour_reg_one_q <= rop_pkg::COL_RST;
      compare_colour_q <= rop_pkg::COL_RST;
      pattern_ctrl_reg_q <= rop_pkg::PCTRL_RST;
      area_x_q <= 32'h0000_0000;
      area_y_q <= 32'h0000_0000;
      origin_q <= 32'h0000_0000;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q <= PWDATA;
      if (hit_col0) colour_reg_zero_q <= PWDATA[15:0];
      if (hit_col1) colour_reg_one_q <= PWDATA[15:0];
      if (hit_cmpc) compare_colour_q <= PWDATA[15:0];
      if (hit_pctrl) pattern_ctrl_reg_q <= PWDATA[15:0];
      if (hit_ax) area_x_q <= PWDATA;
      if (hit_ay) area_y_q <= PWDATA;
      if (hit_org) origin_q <= PWDATA;
    end
  end

  // current pointer and pattern scan
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_q <= 32'h0000_0000;
      pattern_ptr_x_q <= 4'h0;
      pattern_ptr_y_q <= 4'h0;
    end else begin
      if (accept) begin
        cur_q <= {abs_y, abs_x};
      end else if (wr_en & hit_cur) begin
        cur_q <= PWDATA;
      end
      if (accept) begin
        pattern_ptr_x_q <= x_end ? pattern_start_x : pattern_ptr_x_q + 4'h1;
        if (x_end) begin
          pattern_ptr_y_q <= y_end ? pattern_start_y : pattern_ptr_y_q + 4'h1;
        end
      end else if (wr_en & hit_pptr) begin
        pattern_ptr_x_q <= PWDATA[3:0];
        pattern_ptr_y_q <= PWDATA[7:4];
      end
    end
  end

  // stage one: hold the point while the pattern row is read
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_v_q <= 1'b0;
      s1_x_q <= 16'h0000;
      s1_y_q <= 16'h0000;
      s1_fb_q <= 16'h0000;
      s1_src_q <= 16'h0000;
      s1_ppx_q <= 4'h0;
    end else begin
      s1_v_q <= accept;
      if (accept) begin
        s1_x_q <= abs_x;
        s1_y_q <= abs_y;
        s1_fb_q <= FB_RDATA;
        s1_src_q <= PT_SRC_DATA;
        s1_ppx_q <= pattern_ptr_x_q;
      end
    end
  end

  // stage two: write data and flags
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      WR_VALID <= 1'b0;
      WR_SUPPRESS <= 1'b0;
      WR_DATA <= 16'h0000;
      WR_X <= 16'h0000;
      WR_Y <= 16'h0000;
    end else begin
      WR_VALID <= s1_v_q;
      if (s1_v_q) begin
        WR_SUPPRESS <= sup1;
        WR_DATA <= sup1 ? s1_fb_q : merged;
        WR_X <= s1_x_q;
        WR_Y <= s1_y_q;
      end
    end
  end

  // sticky flags, a hardware set wins over a software clear
  wire logic clr_abort = wr_en & hit_st & PWDATA[rop_pkg::ST_ABORT];
  wire logic clr_area = wr_en & hit_st & PWDATA[rop_pkg::ST_AREA];
  wire logic abort_d = abort_hit | (abort_flag_q & ~clr_abort);
  wire logic area_d = ard_hit | (area_detect_flag_q & ~clr_area);
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      abort_flag_q <= 1'b0;
      area_detect_flag_q <= 1'b0;
      stop_q <= 1'b0;
      ABORT <= 1'b0;
      AREA_DETECT <= 1'b0;
      PT_READY <= 1'b0;
    end else begin
      abort_flag_q <= abort_d;
      area_detect_flag_q <= area_d;
      stop_q <= stop_d;
      ABORT <= abort_d;
      AREA_DETECT <= area_d;
      PT_READY <= ~stop_d;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  AST_REPLACE: assert property (
    s1_v_q && raster_op_field == 3'h0 && !sup1 |=>
      (WR_DATA & $past(pmask)) == ($past(col_word) & $past(pmask)))
    else $error("replace did not write colour");
  AST_OR: assert property (
    s1_v_q && raster_op_field == 3'h1 && !sup1 |=>
      WR_DATA == ($past(s1_fb_q) | ($past(col_word) & $past(pmask))))
    else $error("or result wrong");
  AST_AND: assert property (
    s1_v_q && raster_op_field == 3'h2 && !sup1 |=>
      WR_DATA == ($past(s1_fb_q) & ($past(col_word) | ~$past(pmask))))
    else $error("and result wrong");
  AST_XOR: assert property (
    s1_v_q && raster_op_field == 3'h3 && !sup1 |=>
      WR_DATA == ($past(s1_fb_q) ^ ($past(col_word) & $past(pmask))))
    else $error("xor result wrong");
  AST_COND_EQ: assert property (
    s1_v_q && raster_op_field == 3'h4 && rd_pix != cc_pix |=> WR_VALID && WR_SUPPRESS)
    else $error("conditional replace wrote on mismatch");
  AST_COLOUR_SUPPRESS: assert property (
    s1_v_q && !copy_cmd && colour_mode == 2'h1 && !pat_bit |=> WR_SUPPRESS)
    else $error("pattern zero not suppressed");
  AST_EXIT_ABORT: assert property (
    PT_VALID && PT_READY && area_mode == 3'h1 ##1 !in_area |=> ABORT && !PT_READY)
    else $error("exit abort missing");
  AST_OUT_FLAG: assert property (
    s1_v_q && !stop_q && area_mode == 3'h3 && !in_area |=> AREA_DETECT && WR_SUPPRESS)
    else $error("outside clip flag missing");
  AST_FIELD_KEEP: assert property (
    s1_v_q |=> (WR_DATA & ~$past(pmask)) == ($past(s1_fb_q) & ~$past(pmask)))
    else $error("other pixels changed");
endmodule
`default_nettype wire

// ==== verif/rop_fb_model.sv ====
// frame buffer model: answers point reads and takes write-backs
`timescale 1ns/10ps
`default_nettype none
module rop_fb_model (
  input wire logic clk,
  input wire logic pt_valid,
  input wire logic [15:0] pt_x,
  input wire logic [15:0] pt_y,
  input wire logic wr_valid,
  input wire logic wr_sup,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] wr_x,
  input wire logic [15:0] wr_y,
  output logic [15:0] fb_rdata
);
  logic [15:0] mem [16];
  wire logic [3:0] ridx;
  assign ridx = {pt_y[1:0], pt_x[1:0]};
  // scrambled word while no point is offered
  assign fb_rdata = pt_valid ? mem[ridx] : ~mem[ridx];
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'(16'h1111 * i);
    end
  end
  always @(posedge clk) begin
    if (wr_valid && !wr_sup) begin
      mem[{wr_y[1:0], wr_x[1:0]}] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// ==== verif/rop_top_tb.sv ====
// self-checking bench for the raster-op and clip stage
`timescale 1ns/10ps
`default_nettype none
module rop_top_tb;
  logic clk, arst_n, psel, penable, pwrite, cmd_start, pt_valid, pt_rel, err;
  logic pready, pslverr, pt_ready, wr_valid, wr_sup, abort_o, area_o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pt_x, pt_y, src, fb, wr_data, wr_x, wr_y, lx, ly, cmpc;
  logic [15:0] mir [16];
  logic [2:0] cur_op, cur_area;
  logic [16:0] exq [$];
  logic [16:0] mq [$];
  int ix [16] = '{7, 8, 7, 9, 3, 10, 11, 2, 12, 13, 14, 15, 0, 1, 4, 5};
  int failures, samples_checked;
  rop_top dut_u (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CMD_START(cmd_start), .PT_VALID(pt_valid), .PT_REL(pt_rel),
    .PT_X(pt_x), .PT_Y(pt_y), .PT_SRC_DATA(src), .FB_RDATA(fb), .PT_READY(pt_ready),
    .WR_VALID(wr_valid), .WR_SUPPRESS(wr_sup), .WR_DATA(wr_data), .WR_X(wr_x),
    .WR_Y(wr_y), .ABORT(abort_o), .AREA_DETECT(area_o));
  rop_fb_model fbm_u (.clk(clk), .pt_valid(pt_valid), .pt_x(pt_x), .pt_y(pt_y),
    .wr_valid(wr_valid), .wr_sup(wr_sup), .wr_data(wr_data), .wr_x(wr_x), .wr_y(wr_y),
    .fb_rdata(fb));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_valid === 1'b1) begin
      mq.push_back({wr_sup, wr_data});
      lx = wr_x;
      ly = wr_y;
    end
  end
  task final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (pready === 1'b1 || n > 50) break;
    end
    if (n > 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task ctrl(input logic [7:0] cmd, input logic [2:0] area, input logic [1:0] colm,
            input logic [2:0] op);
    cur_op = op;
    cur_area = area;
    apb(1'b1, rop_pkg::OFF_CTRL, {13'h0, 3'h4, cmd, area, colm, op});
  endtask
  task pt(input int idx, input logic [15:0] col, input logic csup);
    logic cond, in, sup;
    logic [15:0] f, res;
    int n;
    f = mir[idx];
    in = (idx % 4 == 1) || (idx % 4 == 2);
    case (cur_op)
      3'h1: res = f | col;
      3'h2: res = f & col;
      3'h3: res = f ^ col;
      default: res = col;
    endcase
    case (cur_op)
      3'h4: cond = (f == cmpc);
      3'h5: cond = (f != cmpc);
      3'h6: cond = (f < col);
      3'h7: cond = (f > col);
      default: cond = 1'b1;
    endcase
    sup = csup | !cond | ((cur_area == 3'h2 || cur_area == 3'h3) && !in);
    sup = sup | ((cur_area == 3'h6 || cur_area == 3'h7) && in);
    sup = sup | (cur_area == 3'h1 && !in) | (cur_area == 3'h5 && in);
    exq.push_back({sup, sup ? f : res});
    if (!sup) mir[idx] = res;
    pt_valid <= 1'b1;
    pt_x <= 16'(idx % 4);
    pt_y <= 16'(idx / 4);
    src <= col;
    n = 0;
    forever begin
      @(posedge clk);
      n++;
      if (pt_ready === 1'b1 || n > 50) break;
    end
    if (n > 50) failures++;
  endtask
  task drain;
    logic [16:0] e, m;
    int n;
    pt_valid <= 1'b0;
    n = 0;
    while (mq.size() < exq.size() && n < 50) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(32'(mq.size()), 32'(exq.size()));
    while (exq.size() > 0) begin
      e = exq.pop_front();
      m = (mq.size() > 0) ? mq.pop_front() : ~e;
      chk({16'h0, m[15:0]}, {16'h0, e[15:0]});
      chk({31'h0, m[16]}, {31'h0, e[16]});
    end
    mq.delete();
  endtask
  task t_rop;
    for (int k = 0; k < 8; k++) begin
      ctrl(8'h10, 3'h0, 2'h0, 3'((k + 4) % 8));
      pt(ix[2 * k], 16'h7777, 1'b0);
      pt(ix[2 * k + 1], 16'h7777, 1'b0);
      drain;
    end
  endtask
  task t_col;
    logic b;
    apb(1'b1, rop_pkg::OFF_PCTRL, 32'h0000_0300);
    apb(1'b1, rop_pkg::OFF_PATWR, 32'h0005_0000);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, rop_pkg::OFF_PPTR, 32'h0);
      ctrl(8'h10, 3'h0, 2'(m), 3'h0);
      for (int k = 0; k < 4; k++) begin
        b = (k % 2 == 0);
        pt(k, (m == 3) ? 16'h0005 : (b ? 16'h2222 : 16'h7777),
           (m == 1 && !b) || (m == 2 && b));
      end
      drain;
      rchk(rop_pkg::OFF_PPTR, 32'h0);
    end
    apb(1'b1, rop_pkg::OFF_PCTRL, 32'h0);
    apb(1'b1, rop_pkg::OFF_PATWR, 32'h0);
    apb(1'b1, rop_pkg::OFF_PPTR, 32'h0);
  endtask
  task t_copy;
    for (int c = 0; c < 2; c++) begin
      ctrl(c ? rop_pkg::CMD_REL_COPY : rop_pkg::CMD_ABS_COPY, 3'h0, 2'h1, 3'h6);
      pt(6, c ? 16'hBBBB : 16'h8888, 1'b0);
      pt(10, c ? 16'hBBBB : 16'h8888, 1'b0);
      drain;
    end
  endtask
  task t_pix;
    cur_op = 3'h0;
    cur_area = 3'h0;
    apb(1'b1, rop_pkg::OFF_CTRL, {13'h0, 3'h2, 8'h10, 3'h0, 2'h0, 3'h0});
    pt(6, (mir[6] & 16'hF0FF) | 16'h0700, 1'b0);
    drain;
    apb(1'b1, rop_pkg::OFF_CTRL, {13'h0, 3'h2, 8'h10, 3'h0, 2'h0, 3'h3});
    pt(7, mir[7] ^ 16'h7000, 1'b0);
    drain;
  endtask
  task t_area;
    logic abort_flag, area_detect_flag;
    for (int m = 0; m < 8; m++) begin
      ctrl(8'h10, 3'(m), 2'h0, 3'h0);
      for (int k = 0; k < 2; k++) begin
        abort_flag = (m == 1 && k == 0) || (m == 5 && k == 1);
        area_detect_flag = (m == 3 && k == 0) || (m == 7 && k == 1);
        pt(k, 16'h7777, 1'b0);
        drain;
        chk({31'h0, area_o}, {31'h0, area_detect_flag});
        chk({31'h0, abort_o}, {31'h0, abort_flag});
        chk({31'h0, pt_ready}, {31'h0, !abort_flag});
        cmd_start <= 1'b1;
        @(posedge clk);
        cmd_start <= 1'b0;
        apb(1'b1, rop_pkg::OFF_STATUS, 32'h3);
        rchk(rop_pkg::OFF_STATUS, 32'h0);
      end
    end
  endtask
  task t_org;
    ctrl(8'h10, 3'h0, 2'h0, 3'h0);
    apb(1'b1, rop_pkg::OFF_ORIGIN, 32'h0001_0001);
    pt(5, 16'h7777, 1'b0);
    drain;
    chk({lx, ly}, 32'h0002_0002);
    pt_rel <= 1'b1;
    pt(1, 16'h7777, 1'b0);
    drain;
    chk({lx, ly}, 32'h0003_0002);
    rchk(rop_pkg::OFF_CURPTR, 32'h0002_0003);
    pt_rel <= 1'b0;
  endtask
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, cmd_start, pt_valid, pt_rel} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    {pt_x, pt_y, src} = 48'h0;
    cmpc = 16'h7777;
    for (int i = 0; i < 16; i++) mir[i] = 16'(16'h1111 * i);
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, pt_ready}, 32'h1);
    rchk(rop_pkg::OFF_CTRL, rop_pkg::CTRL_RST);
    rchk(rop_pkg::OFF_PCTRL, {16'h0, rop_pkg::PCTRL_RST});
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, rop_pkg::OFF_COL0, 32'h7777);
    apb(1'b1, rop_pkg::OFF_COL1, 32'h2222);
    apb(1'b1, rop_pkg::OFF_CMPC, 32'h7777);
    apb(1'b1, rop_pkg::OFF_AREA_X, 32'h0002_0001);
    apb(1'b1, rop_pkg::OFF_AREA_Y, 32'h0003_0000);
    apb(1'b1, rop_pkg::OFF_PCTRL, 32'h0);
    apb(1'b1, rop_pkg::OFF_PATWR, 32'h0);
    apb(1'b1, rop_pkg::OFF_PPTR, 32'h0);
    t_rop;
    t_col;
    t_copy;
    t_pix;
    t_area;
    t_org;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
